// ==== rtl/ilo_adder.sv ====
// Byte adder with the status flags of the add form.
`timescale 1ns/1ps
`default_nettype none
module ilo_adder #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    output logic      [W-1:0] sum,
    output logic              neg,
    output logic              ovf,
    output logic              cry,
    output logic              dcy,
    output logic              zro
);
    logic [W:0] full;
    logic [4:0] low;

    // Digit carry comes from a separate nibble sum so no bit is lost.
    always_comb begin
        full = {1'b0, a} + {1'b0, b};
        low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        sum  = full[W-1:0];
        cry  = full[W];
        dcy  = low[4];
        neg  = full[W-1];
        zro  = (full[W-1:0] == '0);
        // Signed overflow: like signs in, other sign out.
        ovf  = (a[W-1] == b[W-1]) && (full[W-1] != a[W-1]);
    end
endmodule : ilo_adder
`default_nettype wire

// ==== rtl/ilo_decode.sv ====
// Operand address decode and representative indexed execution.
`timescale 1ns/1ps
`default_nettype none
module ilo_decode #(
    parameter int AW = ilo_pkg::ADDR_W
) (
    input  wire logic                    core_clk,
    input  wire logic                    reset_n,
    input  wire logic                    extended_set_enable,
    input  wire logic [AW-1:0]           stack_frame_pointer,
    input  wire logic [ilo_pkg::BANK_W-1:0] bank_select_register,
    input  wire logic                    instr_valid,
    input  wire logic [15:0]             instr_word,
    output logic                         instr_ready,
    output logic                         ext_opcodes_enabled,
    output logic [AW-1:0]                mem_addr,
    output logic                         mem_rd_en,
    input  wire logic [7:0]              mem_rdata,
    output logic                         mem_wr_en,
    output logic [7:0]                   mem_wdata,
    output logic                         addr_indexed,
    output logic [7:0]                   working_reg,
    output logic                         negative_flag,
    output logic                         overflow_flag,
    output logic                         carry_flag,
    output logic                         digit_carry_flag,
    output logic                         zero_flag
);
    typedef enum logic [2:0] {
        ILO_IDLE  = 3'b001,
        ILO_READ  = 3'b010,
        ILO_WRITE = 3'b100
    } ilo_state_e;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // Effective data address of a file operand under the current mode.
    function automatic logic [AW-1:0] eff_addr(
        input logic       ext,
        input logic       acc_sel,
        input logic [7:0] f,
        input logic [AW-1:0] fp,
        input logic [ilo_pkg::BANK_W-1:0] bank
    );
        logic [AW-1:0] r;
        if (acc_sel) begin
            r = AW'({bank, f});
        end else if (ext && f <= ilo_pkg::IDX_LIMIT) begin
            r = fp + AW'(f);
        end else if (f <= ilo_pkg::IDX_LIMIT) begin
            r = AW'({ilo_pkg::ACC_LO_BANK, f});
        end else begin
            r = AW'({ilo_pkg::ACC_HI_BANK, f});
        end
        return r;
    endfunction : eff_addr

    // True when the operand goes through the frame pointer.
    function automatic logic is_idx(
        input logic       ext,
        input logic       acc_sel,
        input logic [7:0] f
    );
        return ext && !acc_sel && (f <= ilo_pkg::IDX_LIMIT);
    endfunction : is_idx

    ////////////////////////////////////////////////////////////////////////
    // Mode bit.

    logic ext_q;
    logic next_ext_q;

    // The config bit is sampled every clock outside reset and cleared to 0
    // under reset, so indexing and the new opcodes always share one source.
    always_comb begin
        next_ext_q = extended_set_enable;
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= next_ext_q;
        end
    end

    assign ext_opcodes_enabled = ext_q;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and datapath.

    ilo_state_e state;
    ilo_state_e next_state;
    ilo_pkg::ilo_kind_e kind;
    ilo_pkg::ilo_kind_e next_kind;
    logic [15:0] op;
    logic [15:0] next_op;
    logic [AW-1:0] next_mem_addr;
    logic next_mem_rd_en;
    logic next_mem_wr_en;
    logic [7:0] next_mem_wdata;
    logic next_addr_indexed;
    logic [7:0] next_working_reg;
    logic [4:0] flags;
    logic [4:0] next_flags;
    logic [7:0] add_sum;
    logic [4:0] add_flags;
    logic known;
    ilo_pkg::ilo_kind_e dec_kind;

    ilo_adder #(
        .W   (8)
    ) u_add (
        .a   (working_reg),
        .b   (mem_rdata),
        .sum (add_sum),
        .neg (add_flags[4]),
        .ovf (add_flags[3]),
        .cry (add_flags[2]),
        .dcy (add_flags[1]),
        .zro (add_flags[0])
    );

    assign instr_ready = (state == ILO_IDLE);

    // Classify the incoming word; unknown forms are simply not taken.
    always_comb begin
        known = 1'b1;
        dec_kind = ilo_pkg::ILO_K_ADD;
        if (instr_word[15:10] == ilo_pkg::OP_ADD) begin
            dec_kind = ilo_pkg::ILO_K_ADD;
        end else if (instr_word[15:12] == ilo_pkg::OP_BSET) begin
            dec_kind = ilo_pkg::ILO_K_BSET;
        end else if (instr_word[15:9] == ilo_pkg::OP_FILL) begin
            dec_kind = ilo_pkg::ILO_K_FILL;
        end else begin
            known = 1'b0;
        end
    end

    // Address is registered on acceptance whatever the mode, so literal
    // and indexed operands reach memory on the same cycle.
    always_comb begin
        next_state = state;
        next_kind = kind;
        next_op = op;
        next_mem_addr = mem_addr;
        next_mem_rd_en = 1'b0;
        next_mem_wr_en = 1'b0;
        next_mem_wdata = mem_wdata;
        next_addr_indexed = addr_indexed;
        next_working_reg = working_reg;
        next_flags = flags;
        unique case (state)
            ILO_IDLE: begin
                if (instr_valid && known) begin
                    next_kind = dec_kind;
                    next_op = instr_word;
                    next_mem_addr = eff_addr(ext_q,
                        instr_word[ilo_pkg::ACC_BIT], instr_word[7:0],
                        stack_frame_pointer, bank_select_register);
                    next_addr_indexed = is_idx(ext_q,
                        instr_word[ilo_pkg::ACC_BIT], instr_word[7:0]);
                    next_mem_rd_en = 1'b1;
                    next_state = ILO_READ;
                end
            end
            ILO_READ: begin
                next_state = ILO_WRITE;
                unique case (kind)
                    ilo_pkg::ILO_K_ADD: begin
                        next_flags = add_flags;
                        if (op[ilo_pkg::DEST_BIT]) begin
                            next_mem_wr_en = 1'b1;
                            next_mem_wdata = add_sum;
                        end else begin
                            next_working_reg = add_sum;
                        end
                    end
                    ilo_pkg::ILO_K_BSET: begin
                        next_mem_wr_en = 1'b1;
                        next_mem_wdata = mem_rdata
                            | (8'h01 << op[ilo_pkg::BIT_LSB +: 3]);
                    end
                    ilo_pkg::ILO_K_FILL: begin
                        next_mem_wr_en = 1'b1;
                        next_mem_wdata = ilo_pkg::FILL_VAL;
                    end
                endcase
            end
            ILO_WRITE: begin
                next_state = ILO_IDLE;
            end
            default: begin
                next_state = ILO_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state <= ILO_IDLE;
            kind <= ilo_pkg::ILO_K_ADD;
            op <= 16'h0000;
            mem_addr <= ilo_pkg::ADDR_RESET;
            mem_rd_en <= 1'b0;
            mem_wr_en <= 1'b0;
            mem_wdata <= 8'h00;
            addr_indexed <= 1'b0;
            working_reg <= ilo_pkg::W_RESET;
            flags <= 5'h00;
        end else begin
            state <= next_state;
            kind <= next_kind;
            op <= next_op;
            mem_addr <= next_mem_addr;
            mem_rd_en <= next_mem_rd_en;
            mem_wr_en <= next_mem_wr_en;
            mem_wdata <= next_mem_wdata;
            addr_indexed <= next_addr_indexed;
            working_reg <= next_working_reg;
            flags <= next_flags;
        end
    end

    assign negative_flag = flags[4];
    assign overflow_flag = flags[3];
    assign carry_flag = flags[2];
    assign digit_carry_flag = flags[1];
    assign zero_flag = flags[0];

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_literal;
        mem_rd_en && !$past(ext_q) && !op[8] |-> mem_addr ==
            ((op[7:0] <= 8'h5F) ? {4'h0, op[7:0]} : {4'hF, op[7:0]});
    endproperty
    a_literal: assert property (p_literal)
        else $error("literal access address wrong");

    property p_banked;
        mem_rd_en && op[8] |->
            mem_addr == {$past(bank_select_register), op[7:0]};
    endproperty
    a_banked: assert property (p_banked)
        else $error("banked address wrong");

    property p_indexed;
        mem_rd_en && addr_indexed |->
            mem_addr == $past(stack_frame_pointer) + {4'h0, op[7:0]};
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed address wrong");

    property p_limit;
        mem_rd_en |-> addr_indexed ==
            ($past(ext_q) && !op[8] && op[7:0] <= 8'h5F);
    endproperty
    a_limit: assert property (p_limit)
        else $error("indexing applied outside threshold");

    property p_zero_fp;
        mem_rd_en && addr_indexed && $past(stack_frame_pointer) == '0
            |-> mem_addr == {4'h0, op[7:0]};
    endproperty
    a_zero_fp: assert property (p_zero_fp)
        else $error("zero pointer does not match access RAM");

    property p_mode;
        mem_rd_en && addr_indexed |-> $past(ext_opcodes_enabled);
    endproperty
    a_mode: assert property (p_mode)
        else $error("indexed mode and opcodes disagree");

    property p_cfg;
        ##1 ext_q == $past(extended_set_enable);
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("mode not following config bit");

    property p_add_w;
        mem_rd_en && kind == ilo_pkg::ILO_K_ADD && !op[9] |=>
            working_reg == 8'($past(working_reg) + $past(mem_rdata))
            && !mem_wr_en;
    endproperty
    a_add_w: assert property (p_add_w)
        else $error("add to W wrong");

    property p_add_m;
        mem_rd_en && kind == ilo_pkg::ILO_K_ADD && op[9] |=>
            mem_wr_en && $stable(working_reg)
            && mem_wdata == 8'($past(working_reg) + $past(mem_rdata))
            && zero_flag == (mem_wdata == 8'h00);
    endproperty
    a_add_m: assert property (p_add_m)
        else $error("add to memory wrong");

    property p_bset;
        mem_rd_en && kind == ilo_pkg::ILO_K_BSET |=> mem_wr_en
            && mem_wdata == ($past(mem_rdata) | (8'h01 << op[11:9]))
            && $stable(flags) ##1 !mem_wr_en;
    endproperty
    a_bset: assert property (p_bset)
        else $error("bit set wrong");

    property p_fill;
        mem_rd_en && kind == ilo_pkg::ILO_K_FILL |=>
            mem_wr_en && mem_wdata == 8'hFF && $stable(flags);
    endproperty
    a_fill: assert property (p_fill)
        else $error("fill wrong");

    property p_busy;
        instr_valid && known && instr_ready |=> !instr_ready [*2] ##1
            instr_ready;
    endproperty
    a_busy: assert property (p_busy)
        else $error("sequence length wrong");

    c_idx_add: cover property (mem_rd_en && addr_indexed
        && kind == ilo_pkg::ILO_K_ADD);
    c_idx_bset: cover property (mem_rd_en && addr_indexed
        && kind == ilo_pkg::ILO_K_BSET);
    c_idx_fill: cover property (mem_rd_en && addr_indexed
        && kind == ilo_pkg::ILO_K_FILL);
    c_hi_access: cover property (mem_rd_en && ext_q && !op[8]
        && !addr_indexed);
endmodule : ilo_decode
`default_nettype wire

// ==== shared/ilo_pkg.sv ====
// Constants shared by the indexed literal offset operand decoder.
package ilo_pkg;
    // Data space and operand field widths.
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;

    // Operand fields inside the instruction word.
    localparam int F_LSB = 0;
    localparam int ACC_BIT = 8;
    localparam int DEST_BIT = 9;
    localparam int BIT_LSB = 9;

    // Largest file operand that is redirected through the frame pointer.
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    // Access bank halves: low part sits in bank 0, high part in top bank.
    localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hF;

    // Opcode matching: top bits that pick each representative form.
    localparam logic [5:0] OP_ADD = 6'h09;  // 0010 01xx
    localparam logic [3:0] OP_BSET = 4'h8;  // 1000 xxxx
    localparam logic [6:0] OP_FILL = 7'h34; // 0110 100x
    localparam logic [7:0] FILL_VAL = 8'hFF;

    // Reset values.
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

    // Forms the executor knows.
    typedef enum logic [2:0] {
        ILO_K_ADD  = 3'b001,
        ILO_K_BSET = 3'b010,
        ILO_K_FILL = 3'b100
    } ilo_kind_e;
endpackage : ilo_pkg

// ==== sim/indexed_literal_offset_decode_tb_top.sv ====
// Self-checking bench for the indexed literal offset operand decoder.
`timescale 1ns/1ps
`default_nettype none
module indexed_literal_offset_decode_tb_top;
    logic        core_clk;
    logic        reset_n;
    logic        extended_set_enable;
    logic [11:0] stack_frame_pointer;
    logic [3:0]  bank_select_register;
    logic        instr_valid;
    logic [15:0] instr_word;
    logic [7:0]  mem_rdata;
    logic        instr_ready;
    logic        ext_opcodes_enabled;
    logic [11:0] mem_addr;
    logic        mem_rd_en;
    logic        mem_wr_en;
    logic [7:0]  mem_wdata;
    logic        addr_indexed;
    logic [7:0]  working_reg;
    wire  [4:0]  flags;
    logic [7:0]  w_model;
    logic [4:0]  f_model;
    logic [7:0]  fv;
    logic [15:0] word;
    int          kind;
    int          bad_count;
    int          checked;

    ////////////////////////////////////////////////////////////////////////
    // Device under test; flags are gathered as {N, OV, C, DC, Z}.
    ilo_decode uut (
        .core_clk             (core_clk),
        .reset_n              (reset_n),
        .extended_set_enable  (extended_set_enable),
        .stack_frame_pointer  (stack_frame_pointer),
        .bank_select_register (bank_select_register),
        .instr_valid          (instr_valid),
        .instr_word           (instr_word),
        .instr_ready          (instr_ready),
        .ext_opcodes_enabled  (ext_opcodes_enabled),
        .mem_addr             (mem_addr),
        .mem_rd_en            (mem_rd_en),
        .mem_rdata            (mem_rdata),
        .mem_wr_en            (mem_wr_en),
        .mem_wdata            (mem_wdata),
        .addr_indexed         (addr_indexed),
        .working_reg          (working_reg),
        .negative_flag        (flags[4]),
        .overflow_flag        (flags[3]),
        .carry_flag           (flags[2]),
        .digit_carry_flag     (flags[1]),
        .zero_flag            (flags[0])
    );

    // Free-running core clock, 8 ns period.
    always #4 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    // Compare one value and count it; values are widened to 16 bits.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Operand goes through the frame pointer: extended, a=0, at most 5Fh.
    function automatic logic exp_idx(input logic ext, input logic [15:0] w);
        return ext && !w[8] && (w[7:0] <= ilo_pkg::IDX_LIMIT);
    endfunction : exp_idx

    // Expected data address; indexed sums wrap at the 12-bit space.
    function automatic logic [11:0] exp_addr(input logic        idx,
                                             input logic [11:0] fp,
                                             input logic [3:0]  bs,
                                             input logic [15:0] w);
        if (w[8]) return {bs, w[7:0]};
        if (idx) return fp + {4'h0, w[7:0]};
        if (w[7:0] > ilo_pkg::IDX_LIMIT)
            return {ilo_pkg::ACC_HI_BANK, w[7:0]};
        return {ilo_pkg::ACC_LO_BANK, w[7:0]};
    endfunction : exp_addr

    // Inputs always move 1 ns after the rising edge, away from sampling.
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask : step

    // The config bit is registered, so one edge must pass before use.
    task automatic set_ext(input logic e);
        extended_set_enable = e;
        step;
        chk(ext_opcodes_enabled, e);
    endtask : set_ext

    // One instruction through the three-cycle walk, checked every cycle.
    task automatic run(input logic [11:0] fp, input logic [3:0] bs,
                       input logic [15:0] w, input logic [7:0] rd);
        logic        idx;
        logic [11:0] ea;
        logic [8:0]  s;
        logic [7:0]  wd;
        logic        wr;
        logic        dc;
        idx = exp_idx(extended_set_enable, w);
        ea = exp_addr(idx, fp, bs, w);
        s  = {1'b0, w_model} + {1'b0, rd};
        dc = ({1'b0, w_model[3:0]} + {1'b0, rd[3:0]}) > 5'h0F;
        wr = 1'b1;
        wd = ilo_pkg::FILL_VAL;
        if (w[15:10] == 6'b001001) begin
            f_model = {s[7], (w_model[7] == rd[7]) && (s[7] != rd[7]),
                       s[8], dc, s[7:0] == 8'h00};
            wd = s[7:0];
            wr = w[9];
            if (!w[9]) w_model = s[7:0];
        end else if (w[15:12] == 4'b1000) begin
            wd = rd | (8'h01 << w[11:9]);
        end
        stack_frame_pointer = fp;
        bank_select_register = bs;
        mem_rdata = rd;
        instr_word = w;
        instr_valid = 1'b1;
        step;
        instr_valid = 1'b0;
        chk(mem_rd_en, 1'b1);
        chk(mem_addr, ea);
        chk(addr_indexed, idx);
        chk(instr_ready, 1'b0);
        step;
        mem_rdata = ~rd;
        chk(mem_wr_en, wr);
        if (wr) chk(mem_wdata, wd);
        chk(working_reg, w_model);
        chk(flags, f_model);
        step;
        chk(instr_ready, 1'b1);
    endtask : run

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    // Watchdog sized well above the roughly 3 us that the tests need.
    initial begin
        #20000;
        bad_count++;
        end_sim;
    end

    // Main sequence: reset, hand-picked corners, refusal, random mix.
    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        extended_set_enable = 1'b0;
        stack_frame_pointer = 12'h000;
        bank_select_register = 4'h0;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        mem_rdata = 8'h00;
        w_model = ilo_pkg::W_RESET;
        f_model = 5'h00;
        bad_count = 0;
        checked = 0;
        void'($urandom(54));
        repeat (4) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        chk(instr_ready, 1'b1);
        chk(working_reg, ilo_pkg::W_RESET);
        chk(mem_addr, ilo_pkg::ADDR_RESET);
        chk(ext_opcodes_enabled, 1'b0);
        $display("test reset done");
        // Legacy mapping first, then the extended mapping at its edges.
        run(12'hA00, 4'h5, 16'h2410, 8'h20);
        run(12'hA00, 4'h5, 16'h2510, 8'h11);
        set_ext(1'b1);
        run(12'hA00, 4'h3, 16'h242C, 8'h20);
        run(12'hA00, 4'h3, 16'h265F, 8'h7F);
        run(12'hA00, 4'h3, 16'h2660, 8'h80);
        run(12'h000, 4'h3, 16'h6810, 8'h00);
        run(12'hFFA, 4'h3, 16'h685F, 8'h00);
        run(12'hA00, 4'h3, 16'h6910, 8'h00);
        for (int b = 0; b < 8; b++) begin
            word = {4'b1000, 3'(b), 1'b0, 8'h0A};
            run(12'hA00, 4'h3, word, 8'h55);
        end
        $display("test corners done");
        // An unknown opcode must be ignored with ready left high.
        instr_word = 16'hFFFF;
        instr_valid = 1'b1;
        step;
        chk(mem_rd_en, 1'b0);
        step;
        chk(instr_ready, 1'b1);
        instr_valid = 1'b0;
        step;
        $display("test refused done");
        // Random mix; every fourth operand sits at the 5Fh/60h border.
        for (int i = 0; i < 80; i++) begin
            kind = $urandom_range(0, 2);
            set_ext(1'($urandom_range(0, 1)));
            fv = (i % 4 == 0) ? 8'h5F + 8'($urandom_range(0, 1))
                              : 8'($urandom);
            if (kind == 0)
                word = {6'b001001, 2'($urandom), fv};
            else if (kind == 1)
                word = {4'b1000, 4'($urandom), fv};
            else
                word = {7'b0110100, 1'($urandom), fv};
            run(12'($urandom), 4'($urandom), word, 8'($urandom));
        end
        $display("test random done");
        end_sim;
    end
endmodule : indexed_literal_offset_decode_tb_top
`default_nettype wire
